// ### rtl/pbd_pkg.sv
// Purpose: Shared constants and types for the pixel combine/skip control block
// Assumes: 32-bit plain register port, byte offsets word aligned
// Notes:   Factor fields hold 1..FAC_MAX, anything else is stored as 1
package pbd_pkg;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_COMB = 4'h4;
  localparam logic [3:0] REG_SKIP = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;

  // Control register fields
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_DPP_EN = 1;
  localparam int CTRL_COLOR  = 2;

  // Combine and skip register fields (same layout)
  localparam int ENG_LSB  = 0;
  localparam int HMETH    = 2;
  localparam int VMETH    = 3;
  localparam int FAC_W    = 3;
  localparam int HFAC_LSB = 4;
  localparam int VFAC_LSB = 8;

  // Status register fields
  localparam int STAT_RUN     = 0;
  localparam int STAT_COMB    = 1;
  localparam int STAT_SKIP    = 2;
  localparam int STAT_DPP_H   = 3;
  localparam int STAT_DPP_V   = 4;
  localparam int STAT_DPP_EN  = 5;

  localparam logic [FAC_W-1:0] FAC_ONE = 3'h1;
  localparam logic [FAC_W-1:0] FAC_MAX = 3'h4;

  // Pixel widths; a sum of FAC_MAX*FAC_MAX cells needs four more bits
  localparam int PIX_W = 12;
  localparam int SUM_W = 16;

  typedef enum logic [1:0] {ENG_TOTAL, ENG_SENSOR, ENG_DPP} pbd_engine_e;
  typedef enum logic       {METH_ADD, METH_AVG} pbd_method_e;

  typedef struct packed {
    logic [FAC_W-1:0] comb_hfac;
    logic [FAC_W-1:0] comb_vfac;
    pbd_method_e      comb_hmeth;
    pbd_method_e      comb_vmeth;
    logic [FAC_W-1:0] skip_hfac;
    logic [FAC_W-1:0] skip_vfac;
  } pbd_sensor_s;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic             eol;
    logic             eof;
  } pbd_pix_s;

  typedef struct packed {
    logic [SUM_W-1:0] data;
    logic             eol;
    logic             eof;
  } pbd_opix_s;

  localparam pbd_sensor_s SENSOR_RST = '{FAC_ONE, FAC_ONE, METH_ADD, METH_ADD, FAC_ONE, FAC_ONE};
endpackage : pbd_pkg

// ### rtl/pbd_fifo.sv
// Purpose: Output pixel FIFO with registered output stage
// Assumes: Single clock, asynchronous active-low reset
// Notes:   in_ready is a flop, so a full FIFO releases the source one edge late
`timescale 1ns/1ps
module pbd_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 16
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;

  assign push = in_valid & in_ready;
  assign pop  = (count != '0) & (~out_valid | out_ready);
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // Storage and pointers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
      count <= next_count;
      in_ready <= next_count < (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) mem[wptr] <= in_data;
  end

  // Output stage refills whenever empty or drained
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : pbd_fifo

// ### rtl/pbd_ctrl.sv
// Purpose: Pixel combine (binning) and skip (decimation) control with digital combine path
// Assumes: Sensor applies the sensor portion and all skipping from sensor_cfg
// Notes:   Digital path combines groups of up to FAC_MAX x FAC_MAX cells
//
// Behaviour
// - Combining and skipping are never active together.
// - Combining settings change only while the stream is stopped.
// - One engine selection covers both axes: total, sensor or digital.
// - Total selection lets the block split work for quality and speed.
// - Combining defaults to the sensor when the sensor supports it.
// - Digital path combines when the sensor cannot or would degrade quality.
// - Additive method sums the grouped cells.
// - Averaging method divides the sum; sensor may lack averaging.
// - Factors set cells merged per axis; 1 means no combining.
// - Skipping only when both combining factors are 1.
// - Skip engine is total or sensor, never the digital path.
// - Skip method fields only offer discard.
// - Skip factor N keeps one pixel per N-cell window.
// - Skip factor 1 means no skipping.
// - Combining only when both skip factors are 1.
// - Digital path disabled forces all combining into the sensor.
// - Colour-interpolated output refuses to disable the digital path.
// - Higher-level changes readjust dependent combine and skip settings.
`timescale 1ns/1ps
module pbd_ctrl #(
  parameter int          COLS       = 1024,
  parameter int          FIFO_DEPTH = 16,
  parameter logic        SENSOR_COMB_OK = 1'b1,
  parameter logic        SENSOR_AVG_OK  = 1'b0
) (
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  input  wire logic [3:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  input  wire logic                     pix_in_valid,
  output logic                          pix_in_ready,
  input  wire pbd_pkg::pbd_pix_s        pix_in,
  output logic                          pix_out_valid,
  input  wire logic                     pix_out_ready,
  output pbd_pkg::pbd_opix_s            pix_out,
  output pbd_pkg::pbd_sensor_s          sensor_cfg
);
  localparam int CW = $clog2(COLS);
  localparam int FW = pbd_pkg::FAC_W;

  // Keep a factor within 1..FAC_MAX
  function automatic logic [FW-1:0] fac_clip(input logic [FW-1:0] f);
    fac_clip = (f == '0 || f > pbd_pkg::FAC_MAX) ? pbd_pkg::FAC_ONE : f;
  endfunction : fac_clip

  // Does the digital path take one axis of combining
  function automatic logic use_dpp(input pbd_pkg::pbd_engine_e eng, input logic dpp_en,
                                   input pbd_pkg::pbd_method_e meth);
    logic sensor_ok;
    sensor_ok = SENSOR_COMB_OK & (meth == pbd_pkg::METH_ADD | SENSOR_AVG_OK);
    use_dpp = 1'b0;
    if (dpp_en) begin
      unique case (eng)
        pbd_pkg::ENG_TOTAL:  use_dpp = ~sensor_ok;
        pbd_pkg::ENG_SENSOR: use_dpp = 1'b0;
        pbd_pkg::ENG_DPP:    use_dpp = 1'b1;
        default:             use_dpp = ~sensor_ok;
      endcase
    end
  endfunction : use_dpp

  function automatic pbd_pkg::pbd_engine_e eng_of(input logic [1:0] f);
    eng_of = (f > 2'(pbd_pkg::ENG_DPP)) ? pbd_pkg::ENG_TOTAL : pbd_pkg::pbd_engine_e'(f);
  endfunction : eng_of

  // Software-visible settings
  logic                 running;
  logic                 dpp_en;
  logic                 color_fmt;
  pbd_pkg::pbd_engine_e comb_eng;
  pbd_pkg::pbd_method_e comb_hmeth;
  pbd_pkg::pbd_method_e comb_vmeth;
  logic [FW-1:0]        comb_hfac;
  logic [FW-1:0]        comb_vfac;
  pbd_pkg::pbd_engine_e skip_eng;
  logic [FW-1:0]        skip_hfac;
  logic [FW-1:0]        skip_vfac;

  logic          wr_ctrl;
  logic          wr_comb;
  logic          wr_skip;
  logic [FW-1:0] w_hfac;
  logic [FW-1:0] w_vfac;
  logic          w_nonunit;
  logic          comb_active;
  logic          skip_active;
  logic          dpp_h;
  logic          dpp_v;

  assign wr_ctrl   = reg_wr & (reg_addr == pbd_pkg::REG_CTRL);
  assign wr_comb   = reg_wr & (reg_addr == pbd_pkg::REG_COMB) & ~running;
  assign wr_skip   = reg_wr & (reg_addr == pbd_pkg::REG_SKIP);
  assign w_hfac    = fac_clip(reg_wdata[pbd_pkg::HFAC_LSB +: FW]);
  assign w_vfac    = fac_clip(reg_wdata[pbd_pkg::VFAC_LSB +: FW]);
  assign w_nonunit = (w_hfac != pbd_pkg::FAC_ONE) | (w_vfac != pbd_pkg::FAC_ONE);
  assign comb_active = (comb_hfac != pbd_pkg::FAC_ONE) | (comb_vfac != pbd_pkg::FAC_ONE);
  assign skip_active = (skip_hfac != pbd_pkg::FAC_ONE) | (skip_vfac != pbd_pkg::FAC_ONE);
  assign dpp_h = use_dpp(comb_eng, dpp_en, comb_hmeth);
  assign dpp_v = use_dpp(comb_eng, dpp_en, comb_vmeth);

  // Control: stream run, digital path enable, colour format
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      running <= 1'b0;
      dpp_en <= 1'b1;
      color_fmt <= 1'b0;
    end else if (wr_ctrl) begin
      running <= reg_wdata[pbd_pkg::CTRL_RUN];
      color_fmt <= reg_wdata[pbd_pkg::CTRL_COLOR];
      dpp_en <= reg_wdata[pbd_pkg::CTRL_DPP_EN] | reg_wdata[pbd_pkg::CTRL_COLOR];
    end
  end

  // Combining settings; a skip write may reset the factors while stopped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      comb_eng <= pbd_pkg::ENG_TOTAL;
      comb_hmeth <= pbd_pkg::METH_ADD;
      comb_vmeth <= pbd_pkg::METH_ADD;
      comb_hfac <= pbd_pkg::FAC_ONE;
      comb_vfac <= pbd_pkg::FAC_ONE;
    end else if (wr_comb) begin
      comb_eng <= eng_of(reg_wdata[pbd_pkg::ENG_LSB +: 2]);
      comb_hmeth <= pbd_pkg::pbd_method_e'(reg_wdata[pbd_pkg::HMETH]);
      comb_vmeth <= pbd_pkg::pbd_method_e'(reg_wdata[pbd_pkg::VMETH]);
      comb_hfac <= w_hfac;
      comb_vfac <= w_vfac;
    end else if (wr_skip & w_nonunit & ~running) begin
      comb_hfac <= pbd_pkg::FAC_ONE;
      comb_vfac <= pbd_pkg::FAC_ONE;
    end
  end

  // Skip settings; a non-unit write is refused while streaming with combining on, since
  // the combine factors cannot then be released
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      skip_eng <= pbd_pkg::ENG_TOTAL;
      skip_hfac <= pbd_pkg::FAC_ONE;
      skip_vfac <= pbd_pkg::FAC_ONE;
    end else if (wr_skip & ~(running & comb_active & w_nonunit)) begin
      skip_eng <= (eng_of(reg_wdata[pbd_pkg::ENG_LSB +: 2]) == pbd_pkg::ENG_SENSOR) ?
                  pbd_pkg::ENG_SENSOR : pbd_pkg::ENG_TOTAL;
      skip_hfac <= w_hfac;
      skip_vfac <= w_vfac;
    end else if (wr_comb & w_nonunit) begin
      skip_hfac <= pbd_pkg::FAC_ONE;
      skip_vfac <= pbd_pkg::FAC_ONE;
    end
  end

  // Sensor portion: every skip, and each combine axis not taken digitally
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sensor_cfg <= pbd_pkg::SENSOR_RST;
    end else begin
      sensor_cfg.comb_hfac <= dpp_h ? pbd_pkg::FAC_ONE : comb_hfac;
      sensor_cfg.comb_vfac <= dpp_v ? pbd_pkg::FAC_ONE : comb_vfac;
      sensor_cfg.comb_hmeth <= comb_hmeth;
      sensor_cfg.comb_vmeth <= comb_vmeth;
      sensor_cfg.skip_hfac <= comb_active ? pbd_pkg::FAC_ONE : skip_hfac;
      sensor_cfg.skip_vfac <= comb_active ? pbd_pkg::FAC_ONE : skip_vfac;
    end
  end

  // Register read, data in the cycle after the strobe; methods of skip read as discard
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      unique case (reg_addr)
        pbd_pkg::REG_CTRL: begin
          reg_rdata[pbd_pkg::CTRL_RUN] <= running;
          reg_rdata[pbd_pkg::CTRL_DPP_EN] <= dpp_en;
          reg_rdata[pbd_pkg::CTRL_COLOR] <= color_fmt;
        end
        pbd_pkg::REG_COMB: begin
          reg_rdata[pbd_pkg::ENG_LSB +: 2] <= comb_eng;
          reg_rdata[pbd_pkg::HMETH] <= comb_hmeth;
          reg_rdata[pbd_pkg::VMETH] <= comb_vmeth;
          reg_rdata[pbd_pkg::HFAC_LSB +: FW] <= comb_hfac;
          reg_rdata[pbd_pkg::VFAC_LSB +: FW] <= comb_vfac;
        end
        pbd_pkg::REG_SKIP: begin
          reg_rdata[pbd_pkg::ENG_LSB +: 2] <= skip_eng;
          reg_rdata[pbd_pkg::HFAC_LSB +: FW] <= skip_hfac;
          reg_rdata[pbd_pkg::VFAC_LSB +: FW] <= skip_vfac;
        end
        pbd_pkg::REG_STAT: begin
          reg_rdata[pbd_pkg::STAT_RUN] <= running;
          reg_rdata[pbd_pkg::STAT_COMB] <= comb_active;
          reg_rdata[pbd_pkg::STAT_SKIP] <= skip_active & ~comb_active;
          reg_rdata[pbd_pkg::STAT_DPP_H] <= dpp_h;
          reg_rdata[pbd_pkg::STAT_DPP_V] <= dpp_v;
          reg_rdata[pbd_pkg::STAT_DPP_EN] <= dpp_en;
        end
        default: reg_rdata <= '0;
      endcase
    end
  end

  // Digital combine path: horizontal sum in a register, vertical sum in a
  // line memory indexed by output column
  logic [FW-1:0]             hf;
  logic [FW-1:0]             vf;
  logic [FW-1:0]             hcnt;
  logic [FW-1:0]             vcnt;
  logic [CW-1:0]             gcol;
  logic [pbd_pkg::SUM_W-1:0] hsum;
  logic [pbd_pkg::SUM_W-1:0] next_hsum;
  logic [pbd_pkg::SUM_W-1:0] vsum;
  logic [pbd_pkg::SUM_W-1:0] line_acc [COLS];
  logic [4:0]                divisor;
  logic                      take;
  logic                      hdone;
  logic                      vdone;
  logic                      fifo_push;
  pbd_pkg::pbd_opix_s        fifo_in;

  assign hf = dpp_h ? comb_hfac : pbd_pkg::FAC_ONE;
  assign vf = dpp_v ? comb_vfac : pbd_pkg::FAC_ONE;
  assign take = pix_in_valid & pix_in_ready & running;
  assign next_hsum = ((hcnt == '0) ? '0 : hsum) + pbd_pkg::SUM_W'(pix_in.data);
  assign hdone = (hcnt == hf - FAC_ONE_W()) | pix_in.eol;
  assign vdone = (vcnt == vf - FAC_ONE_W()) | pix_in.eof;
  assign vsum = ((vcnt == '0) ? '0 : line_acc[gcol]) + next_hsum;
  assign divisor = 5'((comb_hmeth == pbd_pkg::METH_AVG) ? hf : pbd_pkg::FAC_ONE) *
                   5'((comb_vmeth == pbd_pkg::METH_AVG) ? vf : pbd_pkg::FAC_ONE);
  assign fifo_push = take & hdone & vdone;
  assign fifo_in.data = pbd_pkg::SUM_W'(vsum / pbd_pkg::SUM_W'(divisor));
  assign fifo_in.eol = pix_in.eol;
  assign fifo_in.eof = pix_in.eof;

  function automatic logic [FW-1:0] FAC_ONE_W();
    FAC_ONE_W = pbd_pkg::FAC_ONE;
  endfunction : FAC_ONE_W

  // Group counters, restarted when streaming stops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hcnt <= '0;
      vcnt <= '0;
      gcol <= '0;
      hsum <= '0;
    end else if (!running) begin
      hcnt <= '0;
      vcnt <= '0;
      gcol <= '0;
    end else if (take) begin
      hsum <= next_hsum;
      hcnt <= hdone ? '0 : hcnt + 1'b1;
      if (hdone) gcol <= pix_in.eol ? '0 : gcol + 1'b1;
      if (pix_in.eol) vcnt <= vdone ? '0 : vcnt + 1'b1;
    end
  end

  // Partial vertical sums wait in the line memory
  always_ff @(posedge core_clk) begin
    if (take & hdone & ~vdone) line_acc[gcol] <= vsum;
  end

  pbd_fifo #(
    .W     ($bits(pbd_pkg::pbd_opix_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (fifo_push),
    .in_ready  (pix_in_ready),
    .in_data   (fifo_in),
    .out_valid (pix_out_valid),
    .out_ready (pix_out_ready),
    .out_data  (pix_out)
  );
endmodule : pbd_ctrl

// ### bench/pbd_ctrl_properties.sv
// Purpose: Concurrent checks on the combine/skip control block ports
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Control bits are shadowed from bus writes to judge lock and path rules
`timescale 1ns/1ps
module pbd_ctrl_props (
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [31:0]          reg_rdata,
  input  wire logic                 pix_in_ready,
  input  wire logic                 pix_out_valid,
  input  wire logic                 pix_out_ready,
  input  wire pbd_pkg::pbd_opix_s   pix_out,
  input  wire pbd_pkg::pbd_sensor_s sensor_cfg
);
  logic       run_q;
  logic       col_q;
  logic       dpp_q;
  logic [2:0] hf_q;
  wire        ctrl_wr = reg_wr && reg_addr == pbd_pkg::REG_CTRL;
  wire        comb_wr = reg_wr && reg_addr == pbd_pkg::REG_COMB;
  wire        stat_rd = reg_rd && reg_addr == pbd_pkg::REG_STAT;
  wire        comb_on = sensor_cfg.comb_hfac != pbd_pkg::FAC_ONE || sensor_cfg.comb_vfac != pbd_pkg::FAC_ONE;
  wire        skip_on = sensor_cfg.skip_hfac != pbd_pkg::FAC_ONE || sensor_cfg.skip_vfac != pbd_pkg::FAC_ONE;

  // Shadow of the control word; colour output always keeps the digital path on
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
      col_q <= 1'b0;
      dpp_q <= 1'b1;
    end else if (ctrl_wr) begin
      run_q <= reg_wdata[pbd_pkg::CTRL_RUN];
      col_q <= reg_wdata[pbd_pkg::CTRL_COLOR];
      dpp_q <= reg_wdata[pbd_pkg::CTRL_DPP_EN] | reg_wdata[pbd_pkg::CTRL_COLOR];
    end
  end

  // Last horizontal factor written, for the sensor portion check
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hf_q <= 3'h1;
    end else if (comb_wr) begin
      hf_q <= reg_wdata[6:4];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  cfg_excl_a: assert property (!(comb_on && skip_on))
    else $error("sensor combine and skip both active");
  stat_excl_a: assert property (stat_rd |=> !(reg_rdata[pbd_pkg::STAT_COMB] && reg_rdata[pbd_pkg::STAT_SKIP]))
    else $error("status shows combine and skip together");
  skip_fields_a: assert property (reg_rd && reg_addr == pbd_pkg::REG_SKIP |=>
      reg_rdata[3:2] == 2'h0 && reg_rdata[1:0] != 2'h2)
    else $error("skip engine or method field illegal");
  comb_lock_a: assert property (run_q && !ctrl_wr && !$past(ctrl_wr) |=>
      $stable({sensor_cfg.comb_hfac, sensor_cfg.comb_vfac}))
    else $error("combine factors moved while streaming");
  comb_set_a: assert property (!run_q && comb_wr && reg_wdata[1:0] == 2'h1 && !reg_wdata[2] &&
      reg_wdata[6:4] inside {[3'h1:3'h4]} |-> ##[1:2] sensor_cfg.comb_hfac == hf_q)
    else $error("sensor combine factor not applied");
  colour_dpp_a: assert property (reg_rd && reg_addr == pbd_pkg::REG_CTRL && col_q |=>
      reg_rdata[pbd_pkg::CTRL_DPP_EN])
    else $error("digital path off with colour output");
  dpp_off_a: assert property (stat_rd && !dpp_q |=> reg_rdata[4:3] == 2'h0)
    else $error("digital path combining while disabled");
  unmap_rd_a: assert property (reg_rd && !(reg_addr inside {4'h0, 4'h4, 4'h8, 4'hc}) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  out_hold_a: assert property (pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out))
    else $error("output pixel dropped under stall");

  cover property (stat_rd ##1 reg_rdata[pbd_pkg::STAT_SKIP]);
  cover property (!pix_in_ready ##1 !pix_in_ready);
  cover property (pix_out_valid && !pix_out_ready);
  cover property (comb_wr && run_q);
endmodule : pbd_ctrl_props

bind pbd_ctrl pbd_ctrl_props u_props (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .pix_in_ready, .pix_out_valid, .pix_out_ready, .pix_out, .sensor_cfg);

// ### bench/pbd_partner.sv
// Purpose: Sensor-side pixel source and output-side sink for the control block
// Assumes: Bench loads tx with whole frames; hold stalls the sink fully
// Notes:   Idle input data toggles each cycle so a stale pixel never looks fresh
`timescale 1ns/1ps
module pbd_partner (
  input  wire logic               core_clk,
  input  wire logic               hold,
  output logic                    pix_in_valid,
  input  wire logic               pix_in_ready,
  output pbd_pkg::pbd_pix_s       pix_in,
  input  wire logic               pix_out_valid,
  output logic                    pix_out_ready,
  input  wire pbd_pkg::pbd_opix_s pix_out
);
  pbd_pkg::pbd_pix_s  tx[$];
  pbd_pkg::pbd_opix_s rx[$];

  initial begin
    pix_in_valid  = 1'b0;
    pix_in        = '0;
    pix_out_ready = 1'b0;
  end

  // Source holds a pixel until taken; sink also stalls at random
  always @(posedge core_clk) begin
    if (pix_in_valid && pix_in_ready) void'(tx.pop_front());
    if (pix_out_valid && pix_out_ready) rx.push_back(pix_out);
    pix_in_valid  <= tx.size() > 0;
    pix_in        <= (tx.size() > 0) ? tx[0] : ~pix_in;
    pix_out_ready <= !hold && ($urandom_range(3) != 0);
  end
endmodule : pbd_partner

// ### bench/pbd_ctrl_test.sv
// Purpose: Self-checking bench for the combine/skip control block
// Assumes: Default parameters, sensor combines but cannot average
// Notes:   Register fields built from the package layout
`timescale 1ns/1ps
module pbd_ctrl_test;
  logic                 core_clk    = 1'b0;
  logic                 arst_n      = 1'b0;
  logic                 reg_wr      = 1'b0;
  logic                 reg_rd      = 1'b0;
  logic                 hold        = 1'b0;
  logic [3:0]           reg_addr    = 4'h0;
  logic [31:0]          reg_wdata   = 32'h0;
  logic [31:0]          reg_rdata;
  logic                 pix_in_valid;
  logic                 pix_in_ready;
  logic                 pix_out_valid;
  logic                 pix_out_ready;
  pbd_pkg::pbd_pix_s    pix_in;
  pbd_pkg::pbd_opix_s   pix_out;
  pbd_pkg::pbd_sensor_s sensor_cfg;
  int                   miscompares = 0;
  int                   num_checks  = 0;
  int                   cyc         = 0;
  logic [11:0]          frm[$];

  pbd_ctrl DUT (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pix_in_valid,
    .pix_in_ready, .pix_in, .pix_out_valid, .pix_out_ready, .pix_out, .sensor_cfg);
  pbd_partner prt (.core_clk, .hold, .pix_in_valid, .pix_in_ready, .pix_in, .pix_out_valid, .pix_out_ready,
    .pix_out);

  always #10 core_clk = ~core_clk;

  task automatic test_done();
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // Hang guard: the full run needs only a few hundred cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data arrive in the cycle after the strobe and hold until the next read
  task automatic rd(logic [3:0] a, logic [31:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  task automatic send(int cols, int lines);
    pbd_pkg::pbd_pix_s p;
    frm.delete();
    prt.rx.delete();
    @(negedge core_clk);
    for (int i = 0; i < cols * lines; i++) begin
      p.data = 12'($urandom);
      p.eol  = (i % cols) == cols - 1;
      p.eof  = i == cols * lines - 1;
      frm.push_back(p.data);
      prt.tx.push_back(p);
    end
  endtask : send

  task automatic wait_rx(int n);
    for (int i = 0; i < 3000 && prt.rx.size() < n; i++) @(posedge core_clk);
    chk(prt.rx.size(), n);
  endtask : wait_rx

  // Out-of-range factors read back as 1, engine 3 as total
  function automatic logic [31:0] comb_exp(logic [10:0] w);
    logic [2:0] h;
    logic [2:0] v;
    logic [1:0] e;
    h = (w[6:4] == 3'h0 || w[6:4] > 3'h4) ? 3'h1 : w[6:4];
    v = (w[10:8] == 3'h0 || w[10:8] > 3'h4) ? 3'h1 : w[10:8];
    e = (w[1:0] == 2'h3) ? 2'h0 : w[1:0];
    return {21'h0, v, 1'b0, h, w[3:2], e};
  endfunction : comb_exp

  initial begin
    logic [10:0] w;
    void'($urandom(76));
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(pbd_pkg::REG_CTRL, 32'h2);
    rd(pbd_pkg::REG_COMB, 32'h110);
    rd(pbd_pkg::REG_SKIP, 32'h110);
    rd(pbd_pkg::REG_STAT, 32'h20);
    rd(4'h1, 32'h0);
    repeat (6) begin
      w = 11'($urandom) & 11'h77f;
      wr(pbd_pkg::REG_COMB, {21'h0, w});
      rd(pbd_pkg::REG_COMB, comb_exp(w));
    end
    // Digital 2x2 group, horizontal average and vertical sum
    wr(pbd_pkg::REG_COMB, 32'h226);
    rd(pbd_pkg::REG_SKIP, 32'h110);
    wr(pbd_pkg::REG_CTRL, 32'h3);
    wr(pbd_pkg::REG_COMB, 32'h110);
    rd(pbd_pkg::REG_COMB, 32'h226);
    rd(pbd_pkg::REG_STAT, 32'h3b);
    send(4, 2);
    wait_rx(2);
    for (int g = 0; g < 2; g++) chk(prt.rx[g].data, (frm[2*g] + frm[2*g+1] + frm[4+2*g] + frm[5+2*g]) / 2);
    wr(pbd_pkg::REG_CTRL, 32'h2);
    wr(pbd_pkg::REG_COMB, 32'h110);
    wr(pbd_pkg::REG_SKIP, 32'h221);
    rd(pbd_pkg::REG_SKIP, 32'h221);
    chk(sensor_cfg.skip_hfac, 32'h2);
    chk(sensor_cfg.comb_vfac, 32'h1);
    rd(pbd_pkg::REG_STAT, 32'h24);
    wr(pbd_pkg::REG_COMB, 32'h221);
    rd(pbd_pkg::REG_SKIP, 32'h111);
    rd(pbd_pkg::REG_STAT, 32'h22);
    wr(pbd_pkg::REG_COMB, 32'h110);
    wr(pbd_pkg::REG_SKIP, 32'h22e);
    rd(pbd_pkg::REG_SKIP, 32'h220);
    wr(pbd_pkg::REG_SKIP, 32'h110);
    wr(pbd_pkg::REG_COMB, 32'h220);
    rd(pbd_pkg::REG_STAT, 32'h22);
    wr(pbd_pkg::REG_COMB, 32'h224);
    rd(pbd_pkg::REG_STAT, 32'h2a);
    wr(pbd_pkg::REG_CTRL, 32'h4);
    rd(pbd_pkg::REG_CTRL, 32'h6);
    wr(pbd_pkg::REG_CTRL, 32'h0);
    rd(pbd_pkg::REG_STAT, 32'h2);
    chk(sensor_cfg.comb_hfac, 32'h2);
    // Unit factors pass pixels through; stalled sink fills the buffer
    wr(pbd_pkg::REG_COMB, 32'h110);
    wr(pbd_pkg::REG_CTRL, 32'h3);
    hold <= 1'b1;
    send(6, 4);
    for (int i = 0; i < 200 && pix_in_ready === 1'b1; i++) @(negedge core_clk);
    chk(pix_in_ready, 32'h0);
    @(posedge core_clk);
    hold <= 1'b0;
    wait_rx(24);
    for (int i = 0; i < 24; i++) chk(prt.rx[i].data, frm[i]);
    for (int i = 0; i < 24; i++) chk({prt.rx[i].eol, prt.rx[i].eof}, {i % 6 == 5, i == 23});
    test_done();
  end
endmodule : pbd_ctrl_test
